// File: design/exec_pkg.sv
// Constants, types and decode helpers for the transfer and arithmetic unit.
// Function
// - Blank flag kept, zero entry forces zero
// - Result-dependent flags follow the operation outcome
// - Restore code reloads the saved flags
// - Each instruction cycle is one CPU clock
// - Offset byte move: 2 bytes, 6 cycles
// - Accumulator-to-register move rejects the accumulator
// - Offset swap: both values swap, 8 cycles
// - Word transfers accept only the three pairs
// - Offset add: sum to accumulator, flags updated
// - Short-direct add immediate writes back, 6 cycles
// - Register add-with-carry adds carry, 4 cycles
// - Absolute add-with-carry: 3 bytes, 8 cycles
// - Short-direct subtract immediate writes back, borrow
// - Absolute subtract: difference and borrow stored
// - Base-pair subtract: 1 byte, 6 cycles
// - Register field selects X A C B E D L H
// - Short-direct addresses stay in fixed window
package exec_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_PSW = 8'h08;
	localparam logic [7:0] OFF_REGS_LO = 8'h0c;
	localparam logic [7:0] OFF_REGS_HI = 8'h10;
	localparam logic [7:0] OFF_SAVED = 8'h14;
	localparam logic [7:0] PSW_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int PSW_Z = 6;
	localparam int PSW_AC = 4;
	localparam int PSW_CY = 0;

	// ----------------------------------------------------------------
	// Operands and timing
	// ----------------------------------------------------------------
	localparam logic [2:0] REG_A = 3'h1;
	localparam logic [1:0] RP_AX = 2'h0;
	localparam logic [7:0] SADDR_SPLIT = 8'h20;
	localparam logic [7:0] SADDR_PAGE_LO = 8'hfe;
	localparam logic [7:0] SADDR_PAGE_HI = 8'hff;
	localparam logic [15:0] SADDR_LOWEST = 16'hfe20;
	localparam logic [15:0] SADDR_HIGHEST = 16'hff1f;
	localparam logic [3:0] CYCLES_SHORT = 4'h4;
	localparam logic [3:0] CYCLES_MID = 4'h6;
	localparam logic [3:0] CYCLES_LONG = 4'h8;
	localparam logic [3:0] CYCLES_NONE = 4'h0;
	localparam logic [1:0] BYTES_ONE = 2'h1;
	localparam logic [1:0] BYTES_TWO = 2'h2;
	localparam logic [1:0] BYTES_THREE = 2'h3;
	localparam logic [3:0] READ_CNT = 4'h0;
	localparam logic [3:0] CAPTURE_CNT = 4'h2;

	typedef enum logic [4:0] {
		OP_MOV_A_HLB, OP_MOV_HLB_A, OP_MOV_R_A, OP_MOV_A_R, OP_XCH_A_HLB,
		OP_WORD_TRANSFER_OP_AX_RP, OP_WORD_TRANSFER_OP_RP_AX, OP_WORD_SWAP_OP_AX_RP, OP_ADD_A_HLB,
		OP_ADD_SADDR_IMM, OP_ADD_WITH_CARRY_OP_A_R, OP_ADD_WITH_CARRY_OP_A_ABS, OP_SUB_SADDR_IMM,
		OP_SUB_A_ABS, OP_SUB_A_HL, OP_MOV_PSW_IMM, OP_MOV_PSW_A,
		OP_SAVE_PSW, OP_RESTORE_PSW
	} op_type;

	typedef struct packed {
		logic [15:0] imm;
		logic [1:0] rp;
		logic [2:0] r;
		op_type op;
	} instr_type;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} mem_req_type;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] op_cycles(input op_type op);
		unique case (op)
			OP_MOV_R_A, OP_MOV_A_R, OP_WORD_TRANSFER_OP_AX_RP, OP_WORD_TRANSFER_OP_RP_AX,
			OP_ADD_WITH_CARRY_OP_A_R, OP_MOV_PSW_A, OP_SAVE_PSW,
			OP_RESTORE_PSW: op_cycles = CYCLES_SHORT;
			OP_MOV_A_HLB, OP_MOV_HLB_A, OP_ADD_A_HLB, OP_ADD_SADDR_IMM,
			OP_SUB_SADDR_IMM, OP_SUB_A_HL,
			OP_MOV_PSW_IMM: op_cycles = CYCLES_MID;
			OP_XCH_A_HLB, OP_WORD_SWAP_OP_AX_RP, OP_ADD_WITH_CARRY_OP_A_ABS,
			OP_SUB_A_ABS: op_cycles = CYCLES_LONG;
			default: op_cycles = CYCLES_NONE;
		endcase
	endfunction

	function automatic logic [1:0] op_bytes(input op_type op);
		unique case (op)
			OP_WORD_TRANSFER_OP_AX_RP, OP_WORD_TRANSFER_OP_RP_AX, OP_WORD_SWAP_OP_AX_RP, OP_SUB_A_HL,
			OP_SAVE_PSW, OP_RESTORE_PSW: op_bytes = BYTES_ONE;
			OP_ADD_SADDR_IMM, OP_ADD_WITH_CARRY_OP_A_ABS, OP_SUB_SADDR_IMM,
			OP_SUB_A_ABS, OP_MOV_PSW_IMM: op_bytes = BYTES_THREE;
			default: op_bytes = BYTES_TWO;
		endcase
	endfunction

	function automatic logic [15:0] saddr_map(input logic [7:0] low);
		saddr_map = {(low < SADDR_SPLIT) ? SADDR_PAGE_HI : SADDR_PAGE_LO,
			low};
	endfunction

endpackage

// File: design/byte_adder.sv
// Byte adder and subtractor with carry, auxiliary carry and zero outputs.
module byte_adder (
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic carry_in,
	input wire logic subtract,
	output logic [7:0] result,
	output logic carry_out,
	output logic aux_out,
	output logic zero_out
);

	logic [8:0] full;
	logic [4:0] nibble;

	always_comb begin
		if (subtract) begin
			full = {1'b0, a} - {1'b0, b} - {8'h00, carry_in};
			nibble = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, carry_in};
		end else begin
			full = {1'b0, a} + {1'b0, b} + {8'h00, carry_in};
			nibble = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, carry_in};
		end
	end

	// On subtraction the ninth bit is the borrow, which is what carry holds.
	assign result = full[7:0];
	assign carry_out = full[8];
	assign aux_out = nibble[4];
	assign zero_out = (full[7:0] == 8'h00);

endmodule

// File: design/transfer_arith_exec_unit.sv
// Execution datapath for byte and word transfers, swaps, adds and subtracts.
module transfer_arith_exec_unit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output exec_pkg::mem_req_type mem_req,
	input wire logic [7:0] mem_rdata,
	output logic busy
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] regs [8];
	logic [7:0] program_status_word, saved_psw, mdata, acc, alu_a, alu_b, alu_res;
	logic [3:0] cnt, last_cycles;
	logic [1:0] last_bytes;
	logic [15:0] hl, op_addr;
	exec_pkg::instr_type instr, req;
	exec_pkg::mem_req_type next_mem_req;
	logic illegal, access, wr_idle, instr_write, req_illegal, start_ok;
	logic commit, needs_read, alu_cin, alu_sub, alu_cy, alu_ac, alu_z;
	logic arith, flag_free;

	// Pair p holds its high byte in register 2p+1 and its low byte in 2p.
	function automatic logic [15:0] pair_value(input logic [1:0] p);
		pair_value = {regs[{p, 1'b1}], regs[{p, 1'b0}]};
	endfunction

	assign acc = regs[exec_pkg::REG_A];
	assign hl = pair_value(2'h3);

	// ----------------------------------------------------------------
	// Bus decode and instruction acceptance
	// ----------------------------------------------------------------
	assign pready = 1'b1;
	assign access = psel && penable;
	assign wr_idle = access && pwrite && !busy;
	assign instr_write = wr_idle && (paddr == exec_pkg::OFF_INSTR);
	assign req = exec_pkg::instr_type'(pwdata[25:0]);

	always_comb begin
		req_illegal = (exec_pkg::op_cycles(req.op) == exec_pkg::CYCLES_NONE);
		if (req.op == exec_pkg::OP_MOV_R_A && req.r == exec_pkg::REG_A) begin
			req_illegal = 1'b1;
		end
		if ((req.op == exec_pkg::OP_WORD_TRANSFER_OP_AX_RP ||
			req.op == exec_pkg::OP_WORD_TRANSFER_OP_RP_AX ||
			req.op == exec_pkg::OP_WORD_SWAP_OP_AX_RP) &&
			req.rp == exec_pkg::RP_AX) begin
			req_illegal = 1'b1;
		end
	end

	assign start_ok = instr_write && !req_illegal;

	// ----------------------------------------------------------------
	// Cycle sequencer
	// ----------------------------------------------------------------
	// One count per pclk edge: pclk is the CPU clock that clock control
	// has already selected, so no prescaling is done here.
	assign commit = busy &&
		(cnt == exec_pkg::op_cycles(instr.op) - 4'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b0;
			cnt <= 4'h0;
		end else if (start_ok) begin
			busy <= 1'b1;
			cnt <= 4'h0;
		end else if (commit) begin
			busy <= 1'b0;
		end else if (busy) begin
			cnt <= cnt + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr <= '0;
		end else if (start_ok) begin
			instr <= req;
		end
	end

	// ----------------------------------------------------------------
	// Operand addressing and memory port
	// ----------------------------------------------------------------
	always_comb begin
		op_addr = 16'h0000;
		needs_read = 1'b0;
		unique case (instr.op)
			exec_pkg::OP_MOV_A_HLB, exec_pkg::OP_XCH_A_HLB,
			exec_pkg::OP_ADD_A_HLB: begin
				op_addr = hl + {8'h00, instr.imm[7:0]};
				needs_read = 1'b1;
			end
			exec_pkg::OP_MOV_HLB_A: begin
				op_addr = hl + {8'h00, instr.imm[7:0]};
			end
			exec_pkg::OP_ADD_SADDR_IMM, exec_pkg::OP_SUB_SADDR_IMM: begin
				op_addr = exec_pkg::saddr_map(instr.imm[7:0]);
				needs_read = 1'b1;
			end
			exec_pkg::OP_ADD_WITH_CARRY_OP_A_ABS, exec_pkg::OP_SUB_A_ABS: begin
				op_addr = instr.imm;
				needs_read = 1'b1;
			end
			exec_pkg::OP_SUB_A_HL: begin
				op_addr = hl;
				needs_read = 1'b1;
			end
			default: begin
				op_addr = 16'h0000;
			end
		endcase
	end

	always_comb begin
		next_mem_req = '0;
		if (busy && cnt == exec_pkg::READ_CNT && needs_read) begin
			next_mem_req.re = 1'b1;
			next_mem_req.addr = op_addr;
		end
		if (commit) begin
			unique case (instr.op)
				exec_pkg::OP_MOV_HLB_A, exec_pkg::OP_XCH_A_HLB: begin
					next_mem_req.we = 1'b1;
					next_mem_req.addr = op_addr;
					next_mem_req.wdata = acc;
				end
				exec_pkg::OP_ADD_SADDR_IMM,
				exec_pkg::OP_SUB_SADDR_IMM: begin
					next_mem_req.we = 1'b1;
					next_mem_req.addr = op_addr;
					next_mem_req.wdata = alu_res;
				end
				default: begin
					next_mem_req.we = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req <= '0;
		end else begin
			mem_req <= next_mem_req;
		end
	end

	// Memory answers one cycle after it sees the read strobe.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mdata <= 8'h00;
		end else if (busy && cnt == exec_pkg::CAPTURE_CNT) begin
			mdata <= mem_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Arithmetic
	// ----------------------------------------------------------------
	always_comb begin
		alu_a = acc;
		alu_b = mdata;
		alu_cin = 1'b0;
		alu_sub = 1'b0;
		arith = 1'b1;
		unique case (instr.op)
			exec_pkg::OP_ADD_A_HLB: alu_b = mdata;
			exec_pkg::OP_ADD_SADDR_IMM: begin
				alu_a = mdata;
				alu_b = instr.imm[15:8];
			end
			exec_pkg::OP_ADD_WITH_CARRY_OP_A_R: begin
				alu_b = regs[instr.r];
				alu_cin = program_status_word[exec_pkg::PSW_CY];
			end
			exec_pkg::OP_ADD_WITH_CARRY_OP_A_ABS: begin
				alu_cin = program_status_word[exec_pkg::PSW_CY];
			end
			exec_pkg::OP_SUB_SADDR_IMM: begin
				alu_a = mdata;
				alu_b = instr.imm[15:8];
				alu_sub = 1'b1;
			end
			exec_pkg::OP_SUB_A_ABS, exec_pkg::OP_SUB_A_HL: begin
				alu_sub = 1'b1;
			end
			default: arith = 1'b0;
		endcase
	end

	assign flag_free = !arith &&
		instr.op != exec_pkg::OP_MOV_PSW_IMM &&
		instr.op != exec_pkg::OP_MOV_PSW_A &&
		instr.op != exec_pkg::OP_RESTORE_PSW;

	byte_adder adder (
		.a(alu_a),
		.b(alu_b),
		.carry_in(alu_cin),
		.subtract(alu_sub),
		.result(alu_res),
		.carry_out(alu_cy),
		.aux_out(alu_ac),
		.zero_out(alu_z)
	);

	// ----------------------------------------------------------------
	// General registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) begin
				regs[i] <= exec_pkg::REG_RESET;
			end
		end else if (wr_idle && paddr == exec_pkg::OFF_REGS_LO) begin
			for (int i = 0; i < 4; i++) begin
				regs[i] <= pwdata[8*i +: 8];
			end
		end else if (wr_idle && paddr == exec_pkg::OFF_REGS_HI) begin
			for (int i = 0; i < 4; i++) begin
				regs[i + 4] <= pwdata[8*i +: 8];
			end
		end else if (commit) begin
			unique case (instr.op)
				exec_pkg::OP_MOV_A_HLB, exec_pkg::OP_XCH_A_HLB:
					regs[exec_pkg::REG_A] <= mdata;
				exec_pkg::OP_MOV_R_A: regs[instr.r] <= acc;
				exec_pkg::OP_MOV_A_R: regs[exec_pkg::REG_A] <= regs[instr.r];
				exec_pkg::OP_WORD_TRANSFER_OP_AX_RP: begin
					regs[0] <= regs[{instr.rp, 1'b0}];
					regs[1] <= regs[{instr.rp, 1'b1}];
				end
				exec_pkg::OP_WORD_TRANSFER_OP_RP_AX: begin
					regs[{instr.rp, 1'b0}] <= regs[0];
					regs[{instr.rp, 1'b1}] <= regs[1];
				end
				exec_pkg::OP_WORD_SWAP_OP_AX_RP: begin
					regs[0] <= regs[{instr.rp, 1'b0}];
					regs[1] <= regs[{instr.rp, 1'b1}];
					regs[{instr.rp, 1'b0}] <= regs[0];
					regs[{instr.rp, 1'b1}] <= regs[1];
				end
				exec_pkg::OP_ADD_A_HLB, exec_pkg::OP_ADD_WITH_CARRY_OP_A_R,
				exec_pkg::OP_ADD_WITH_CARRY_OP_A_ABS, exec_pkg::OP_SUB_A_ABS,
				exec_pkg::OP_SUB_A_HL:
					regs[exec_pkg::REG_A] <= alu_res;
				default: regs[exec_pkg::REG_A] <= acc;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Status word and its saved copy
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_status_word <= exec_pkg::PSW_RESET;
		end else if (wr_idle && paddr == exec_pkg::OFF_PSW) begin
			program_status_word <= pwdata[7:0];
		end else if (commit) begin
			if (arith) begin
				program_status_word[exec_pkg::PSW_Z] <= alu_z;
				program_status_word[exec_pkg::PSW_AC] <= alu_ac;
				program_status_word[exec_pkg::PSW_CY] <= alu_cy;
			end else if (instr.op == exec_pkg::OP_MOV_PSW_IMM) begin
				program_status_word <= instr.imm[7:0];
			end else if (instr.op == exec_pkg::OP_MOV_PSW_A) begin
				program_status_word <= acc;
			end else if (instr.op == exec_pkg::OP_RESTORE_PSW) begin
				program_status_word <= saved_psw;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			saved_psw <= exec_pkg::PSW_RESET;
		end else if (wr_idle && paddr == exec_pkg::OFF_SAVED) begin
			saved_psw <= pwdata[7:0];
		end else if (commit && instr.op == exec_pkg::OP_SAVE_PSW) begin
			saved_psw <= program_status_word;
		end
	end

	// ----------------------------------------------------------------
	// Status and bus read path
	// ----------------------------------------------------------------
	// A refused instruction sets the sticky flag; writing one clears it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			illegal <= 1'b0;
		end else if (instr_write && req_illegal) begin
			illegal <= 1'b1;
		end else if (wr_idle && paddr == exec_pkg::OFF_STATUS &&
			pwdata[1]) begin
			illegal <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_bytes <= 2'h0;
			last_cycles <= 4'h0;
		end else if (start_ok) begin
			last_bytes <= exec_pkg::op_bytes(req.op);
			last_cycles <= exec_pkg::op_cycles(req.op);
		end
	end

	// Read data is taken in the setup cycle so that prdata is a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			unique case (paddr)
				exec_pkg::OFF_INSTR: prdata <= {6'h00, instr};
				exec_pkg::OFF_STATUS: prdata <= {20'h00000, last_cycles,
					2'h0, last_bytes, 2'h0, illegal, busy};
				exec_pkg::OFF_PSW: prdata <= {24'h000000, program_status_word};
				exec_pkg::OFF_REGS_LO:
					prdata <= {regs[3], regs[2], regs[1], regs[0]};
				exec_pkg::OFF_REGS_HI:
					prdata <= {regs[7], regs[6], regs[5], regs[4]};
				exec_pkg::OFF_SAVED: prdata <= {24'h000000, saved_psw};
				default: pslverr <= 1'b1;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	flags_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
		commit && flag_free |=> $stable(program_status_word))
		else $error("Flags changed on a flag-free instruction.");

	flags_result_a: assert property (@(posedge pclk) disable iff (!presetn)
		commit && arith |=> program_status_word[exec_pkg::PSW_Z] == $past(alu_z) &&
		program_status_word[exec_pkg::PSW_AC] == $past(alu_ac))
		else $error("Result flags do not match the operation.");

	flags_restore_a: assert property (@(posedge pclk) disable iff (!presetn)
		commit && instr.op == exec_pkg::OP_RESTORE_PSW |=>
		program_status_word == $past(saved_psw))
		else $error("Status word was not restored.");

	move_offset_a: assert property (@(posedge pclk) disable iff (!presetn)
		start_ok && req.op == exec_pkg::OP_MOV_A_HLB |=>
		busy [*6] ##1 !busy)
		else $error("Offset move did not take six cycles.");

	reject_acc_a: assert property (@(posedge pclk) disable iff (!presetn)
		instr_write && req.op == exec_pkg::OP_MOV_R_A &&
		req.r == exec_pkg::REG_A |=> !busy && illegal)
		else $error("Accumulator accepted as move destination.");

	swap_offset_a: assert property (@(posedge pclk) disable iff (!presetn)
		start_ok && req.op == exec_pkg::OP_XCH_A_HLB |=>
		busy [*8] ##1 (!busy && mem_req.we && mem_req.wdata == $past(acc)))
		else $error("Offset swap timing or data wrong.");

	reject_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
		instr_write && (req.op == exec_pkg::OP_WORD_SWAP_OP_AX_RP ||
		req.op == exec_pkg::OP_WORD_TRANSFER_OP_AX_RP ||
		req.op == exec_pkg::OP_WORD_TRANSFER_OP_RP_AX) &&
		req.rp == exec_pkg::RP_AX |=> !busy && illegal)
		else $error("Word accumulator accepted as pair operand.");

	add_offset_a: assert property (@(posedge pclk) disable iff (!presetn)
		commit && instr.op == exec_pkg::OP_ADD_A_HLB |=>
		acc == $past(alu_res) && program_status_word[exec_pkg::PSW_CY] == $past(alu_cy))
		else $error("Offset add result not stored.");

	add_saddr_a: assert property (@(posedge pclk) disable iff (!presetn)
		commit && instr.op == exec_pkg::OP_ADD_SADDR_IMM |=>
		mem_req.we && mem_req.addr == $past(op_addr) &&
		mem_req.wdata == $past(alu_res))
		else $error("Short-direct add did not write back.");

	add_with_carry_op_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
		busy && instr.op == exec_pkg::OP_ADD_WITH_CARRY_OP_A_R |->
		alu_cin == program_status_word[exec_pkg::PSW_CY])
		else $error("Add-with-carry ignored the carry flag.");

	sub_abs_a: assert property (@(posedge pclk) disable iff (!presetn)
		start_ok && req.op == exec_pkg::OP_SUB_A_ABS |=>
		busy [*8] ##1 !busy)
		else $error("Absolute subtract did not take eight cycles.");

	saddr_window_a: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req.re && (instr.op == exec_pkg::OP_ADD_SADDR_IMM ||
		instr.op == exec_pkg::OP_SUB_SADDR_IMM) |->
		mem_req.addr >= exec_pkg::SADDR_LOWEST &&
		mem_req.addr <= exec_pkg::SADDR_HIGHEST)
		else $error("Short-direct address outside its window.");

	psw_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		commit && instr.op == exec_pkg::OP_MOV_PSW_A |=> program_status_word == $past(acc))
		else $error("Status word not loaded from accumulator.");

endmodule

// File: bench/mem_model.sv
// Behavioural memory and register space seen by the execution unit.
module mem_model (
	input wire logic pclk,
	input wire exec_pkg::mem_req_type mem_req,
	output logic [7:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] mem [0:65535];

	// Read data stands for one cycle only, then the inverse is shown, so a
	// capture on the wrong edge picks up a wrong value instead of a lucky one.
	always @(posedge pclk) begin
		if (mem_req.re)
			mem_rdata <= mem[mem_req.addr];
		else
			mem_rdata <= ~mem_rdata;
	end

	always @(posedge pclk) begin
		if (mem_req.we)
			mem[mem_req.addr] <= mem_req.wdata;
	end
endmodule

// File: bench/tb.sv
// Self-checking testbench for the transfer and arithmetic execution unit.
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
	logic [7:0] paddr, mem_rdata;
	logic [31:0] pwdata, prdata;
	exec_pkg::mem_req_type mem_req;
	int fail_count, check_count;

	transfer_arith_exec_unit i_transfer_arith_exec_unit (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.mem_req(mem_req),
		.mem_rdata(mem_rdata),
		.busy(busy)
	);

	mem_model i_mem_model (
		.pclk(pclk),
		.mem_req(mem_req),
		.mem_rdata(mem_rdata)
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Ends at the completion edge with the release scheduled.
	task automatic apb_xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic err;
		apb_xfer(1'b1, a, d, rd, err);
		@(posedge pclk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask,
		input logic [31:0] exp);
		logic [31:0] rd;
		logic err;
		apb_xfer(1'b0, a, 32'h0, rd, err);
		@(posedge pclk);
		check32(rd & mask, exp);
		check1(err, 1'b0);
	endtask

	// Issues one instruction, counts its busy cycles and checks the state.
	task automatic step(input logic [4:0] op, input logic [2:0] r,
		input logic [1:0] rp, input logic [15:0] imm, input logic [3:0] cyc,
		input logic [1:0] nb, input logic [7:0] program_status_word, input logic [31:0] lo,
		input logic [31:0] hi);
		int n;
		logic [31:0] rd;
		logic err;
		apb_xfer(1'b1, exec_pkg::OFF_INSTR,
			{6'h00, imm, rp, r, op}, rd, err);
		n = 0;
		forever begin
			@(negedge pclk);
			if (busy !== 1'b1 || n > 20)
				break;
			n++;
		end
		@(posedge pclk);
		check32(32'(n), {28'h0, cyc});
		if (cyc == 4'h0) begin
			rd_chk(exec_pkg::OFF_STATUS, 32'h2, 32'h2);
			apb_wr(exec_pkg::OFF_STATUS, 32'h2);
		end else begin
			rd_chk(exec_pkg::OFF_STATUS, 32'hf31, {20'h0, cyc, 2'h0, nb, 4'h0});
		end
		rd_chk(exec_pkg::OFF_PSW, 32'hff, {24'h0, program_status_word});
		rd_chk(exec_pkg::OFF_REGS_LO, 32'hffffffff, lo);
		rd_chk(exec_pkg::OFF_REGS_HI, 32'hffffffff, hi);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		tally_and_finish;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] rd;
		logic err;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		i_mem_model.mem[16'h0005] = 8'h3c;
		i_mem_model.mem[16'h0006] = 8'hc8;
		i_mem_model.mem[16'hfe30] = 8'h30;
		i_mem_model.mem[16'hff10] = 8'h80;
		i_mem_model.mem[16'h0020] = 8'h5a;
		i_mem_model.mem[16'h0040] = 8'h5a;
		i_mem_model.mem[16'h0041] = 8'h0f;
		i_mem_model.mem[16'h1000] = 8'h11;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk(exec_pkg::OFF_PSW, 32'hffffffff, 32'h0);
		rd_chk(exec_pkg::OFF_REGS_LO, 32'hffffffff, 32'h0);
		rd_chk(exec_pkg::OFF_SAVED, 32'hffffffff, 32'h0);
		apb_xfer(1'b0, 8'h20, 32'h0, rd, err);
		@(posedge pclk);
		check1(err, 1'b1);
		step(exec_pkg::OP_MOV_A_HLB, 3'h0, 2'h0, 16'h0005,
			4'h6, 2'h2, 8'h00, 32'h3c00, 32'h0);
		step(exec_pkg::OP_MOV_R_A, 3'h1, 2'h0, 16'h0000,
			4'h0, 2'h0, 8'h00, 32'h3c00, 32'h0);
		step(exec_pkg::OP_MOV_HLB_A, 3'h0, 2'h0, 16'h0010,
			4'h6, 2'h2, 8'h00, 32'h3c00, 32'h0);
		step(exec_pkg::OP_ADD_A_HLB, 3'h0, 2'h0, 16'h0006,
			4'h6, 2'h2, 8'h11, 32'h0400, 32'h0);
		step(exec_pkg::OP_ADD_WITH_CARRY_OP_A_R, 3'h0, 2'h0, 16'h0000,
			4'h4, 2'h2, 8'h00, 32'h0500, 32'h0);
		step(exec_pkg::OP_SUB_SADDR_IMM, 3'h0, 2'h0, 16'h3130,
			4'h6, 2'h3, 8'h11, 32'h0500, 32'h0);
		step(exec_pkg::OP_ADD_SADDR_IMM, 3'h0, 2'h0, 16'h8010,
			4'h6, 2'h3, 8'h41, 32'h0500, 32'h0);
		step(exec_pkg::OP_SAVE_PSW, 3'h0, 2'h0, 16'h0000,
			4'h4, 2'h1, 8'h41, 32'h0500, 32'h0);
		rd_chk(exec_pkg::OFF_SAVED, 32'hff, 32'h41);
		step(exec_pkg::OP_MOV_PSW_IMM, 3'h0, 2'h0, 16'h0010,
			4'h6, 2'h3, 8'h10, 32'h0500, 32'h0);
		step(exec_pkg::OP_XCH_A_HLB, 3'h0, 2'h0, 16'h0020,
			4'h8, 2'h2, 8'h10, 32'h5a00, 32'h0);
		step(exec_pkg::OP_SUB_A_ABS, 3'h0, 2'h0, 16'h0040,
			4'h8, 2'h3, 8'h40, 32'h0000, 32'h0);
		step(exec_pkg::OP_RESTORE_PSW, 3'h0, 2'h0, 16'h0000,
			4'h4, 2'h1, 8'h41, 32'h0000, 32'h0);
		step(exec_pkg::OP_ADD_WITH_CARRY_OP_A_ABS, 3'h0, 2'h0, 16'h0041,
			4'h8, 2'h3, 8'h10, 32'h1000, 32'h0);
		step(exec_pkg::OP_MOV_R_A, 3'h2, 2'h0, 16'h0000,
			4'h4, 2'h2, 8'h10, 32'h101000, 32'h0);
		step(exec_pkg::OP_WORD_TRANSFER_OP_RP_AX, 3'h0, 2'h3, 16'h0000,
			4'h4, 2'h1, 8'h10, 32'h101000, 32'h10000000);
		step(exec_pkg::OP_WORD_TRANSFER_OP_AX_RP, 3'h0, 2'h0, 16'h0000,
			4'h0, 2'h0, 8'h10, 32'h101000, 32'h10000000);
		step(exec_pkg::OP_WORD_SWAP_OP_AX_RP, 3'h0, 2'h1, 16'h0000,
			4'h8, 2'h1, 8'h10, 32'h10000010, 32'h10000000);
		step(exec_pkg::OP_MOV_A_R, 3'h3, 2'h0, 16'h0000,
			4'h4, 2'h2, 8'h10, 32'h10001010, 32'h10000000);
		step(exec_pkg::OP_SUB_A_HL, 3'h0, 2'h0, 16'h0000,
			4'h6, 2'h1, 8'h11, 32'h1000ff10, 32'h10000000);
		step(exec_pkg::OP_MOV_PSW_A, 3'h0, 2'h0, 16'h0000,
			4'h4, 2'h2, 8'hff, 32'h1000ff10, 32'h10000000);
		step(5'h13, 3'h0, 2'h0, 16'h0000,
			4'h0, 2'h0, 8'hff, 32'h1000ff10, 32'h10000000);
		check32({24'h0, i_mem_model.mem[16'h0010]}, 32'h3c);
		check32({24'h0, i_mem_model.mem[16'hfe30]}, 32'hff);
		check32({24'h0, i_mem_model.mem[16'hff10]}, 32'h00);
		check32({24'h0, i_mem_model.mem[16'h0020]}, 32'h05);
		tally_and_finish;
	end
endmodule
